/* File: shared/dir_pkg.sv */
// package for the instruction resource decoder: ids, descriptor layout, unit masks
package dir_pkg;

	typedef enum logic [5:0] {
		DIR_I_LSL1,          // logical shift left by one
		DIR_I_LSR1,          // logical shift right by one
		DIR_I_LSL_IMM,       // accumulator logical shift by immediate
		DIR_I_ASR1,          // signed shift right by one
		DIR_I_ASL1,          // signed shift left by one
		DIR_I_ASH_TX,        // accumulator signed shift by temp register
		DIR_I_ASH_IMM,       // accumulator signed shift by immediate
		DIR_I_SOFT_INT,      // software interrupt
		DIR_I_SQR_REG,       // rounded square of source accumulator
		DIR_I_SQR_MEM,       // square of memory operand
		DIR_I_SQRA_REG,      // square and accumulate, registers
		DIR_I_SQRA_MEM,      // square and accumulate, memory operand
		DIR_I_SQRS_REG,      // square and subtract, registers
		DIR_I_SQRS_MEM,      // square and subtract, memory operand
		DIR_I_SQDST,         // square distance, dual memory
		DIR_I_ST_HI,         // store high half
		DIR_I_ST_HI_RND,     // store rounded high half
		DIR_I_ST_LO_SHIMM,   // store low half shifted by immediate
		DIR_I_ST_HI_RNDIMM,  // store rounded high half shifted by immediate
		DIR_I_ST_HI_USAT,    // store unsigned-saturated rounded high half
		DIR_I_ST_HI_USATIMM, // same, shifted by immediate
		DIR_I_ST_DBL,        // store accumulator to long operand
		DIR_I_ST_DBL_USAT,   // store unsigned-saturated to long operand
		DIR_I_ST_HALF_SHR1,  // store both halves shifted right by one
		DIR_I_ST_DUAL_LOHI,  // low half to first, high half to second operand
		DIR_I_SUBC,          // conditional subtract
		DIR_I_SUB_REG,       // register subtract
		DIR_I_SUB_K16,       // subtract 16-bit constant
		DIR_I_SUB_MEM,       // subtract memory operand
		DIR_I_SUB_ACC_TX,    // subtract accumulator shifted by temp register
		DIR_I_SUB_ACC_IMM,   // subtract accumulator shifted by immediate
		DIR_I_SUB_MEM16,     // subtract memory shifted left 16
		DIR_I_SUB_REV16,     // memory shifted left 16 minus accumulator
		DIR_I_SUB_BORROW,    // subtract unsigned memory and borrow
		DIR_I_SUB_UNS,       // subtract unsigned memory
		DIR_I_SUB_DBL,       // subtract long operand
		DIR_I_SUB_DUAL16,    // dual memory subtract, both shifted left 16
		DIR_I_SUB_PAR_ST,    // subtract with parallel store
		DIR_I_SWAP_ACC,      // accumulator swap
		DIR_I_SWAP_AR,       // auxiliary register swap
		DIR_I_SWAP_AR_T,     // auxiliary and temporary register swap
		DIR_I_SWAP_BLOCK,    // four auxiliary registers with four temporaries
		DIR_I_SWAP_T,        // temporary register swap
		DIR_I_BIT_TST,       // test memory bit
		DIR_I_BIT_TST_CLR,   // test and clear memory bit
		DIR_I_BIT_TST_CPL,   // test and complement memory bit
		DIR_I_BIT_TST_SET    // test and set memory bit
	} dir_instr_t;

	typedef enum logic [1:0] {
		DIR_STG_X,
		DIR_STG_AD,
		DIR_STG_D,
		DIR_STG_R
	} dir_stage_t;

	// operator unit mask bit positions
	localparam int DIR_U_W        = 7;
	localparam int DIR_U_DATA_UNIT_ALU   = 0;
	localparam int DIR_U_DATA_UNIT_MAC_ONE  = 1;
	localparam int DIR_U_DATA_UNIT_SHIFTER = 2;
	localparam int DIR_U_DU_SWAP  = 3;
	localparam int DIR_U_ADDRESS_UNIT_ALU   = 4;
	localparam int DIR_U_ADDRESS_UNIT_SWAPPER  = 5;
	localparam int DIR_U_PU_UNIT  = 6;

	typedef struct packed {
		logic                 legal;
		logic                 par_en;
		logic [2:0]           size;
		logic [2:0]           cycles;
		dir_stage_t           stage;
		logic [DIR_U_W-1:0]   units;
		logic [1:0]           data_address_gen;
		logic [1:0]           stack_address_gen;
		logic [1:0]           data_read_bus;
		logic [1:0]           data_write_bus;
	} dir_desc_t;

	typedef struct packed {
		logic       valid;
		dir_instr_t instr;
		logic       dst_au;
		logic       tc_sel;
		logic [3:0] bit_idx;
		logic [15:0] mem_word;
		logic [39:0] source_accumulator;
	} dir_req_t;

	localparam int        DIR_ACC_W      = 40;
	localparam int        DIR_WORD_W     = 16;
	localparam logic      DIR_CARRY_RST  = 1'b0;
	localparam logic      DIR_TFLAG_RST  = 1'b0;
	localparam dir_desc_t DIR_DESC_RST   = '0;
	localparam int        DIR_LATENCY    = 1;

endpackage

/* File: design/dir_bit_modify.sv */
// test-and-modify of one bit of a memory word
`timescale 1ns/1ps
`default_nettype none
module dir_bit_modify
	import dir_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic [W-1:0]         i_word,
	input  wire logic [$clog2(W)-1:0] i_idx,
	input  wire logic                 i_clr,
	input  wire logic                 i_cpl,
	input  wire logic                 i_set,
	output logic                      o_orig_bit,
	output logic [W-1:0]              o_word
);
	if (W < 2) begin
		$error("bit modify width too small");
	end

	always_comb begin
		o_orig_bit = i_word[i_idx];
		o_word     = i_word;
		if (i_clr) begin
			o_word[i_idx] = 1'b0;
		end else if (i_cpl) begin
			o_word[i_idx] = ~i_word[i_idx];
		end else if (i_set) begin
			o_word[i_idx] = 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: design/dir_sub_borrow.sv */
// accumulator minus unsigned word minus borrow, carry out reports no-borrow
`timescale 1ns/1ps
`default_nettype none
module dir_sub_borrow
	import dir_pkg::*;
#(
	parameter int AW = 40,
	parameter int WW = 16
) (
	input  wire logic [AW-1:0] i_acc,
	input  wire logic [WW-1:0] i_word,
	input  wire logic          i_carry,
	input  wire logic          i_use_borrow,
	output logic [AW-1:0]      o_res,
	output logic               o_carry
);
	logic [AW:0] diff;
	logic        borrow_in;

	if (WW >= AW) begin
		$error("word must be narrower than accumulator");
	end

	always_comb begin
		// borrow is the inverse of the stored carry when i_use_borrow is set, else zero
		borrow_in = i_use_borrow & ~i_carry;
		diff      = {1'b0, i_acc} - {{(AW+1-WW){1'b0}}, i_word} - {{AW{1'b0}}, borrow_in};
		o_res     = diff[AW-1:0];
		o_carry   = ~diff[AW];
	end
endmodule
`default_nettype wire

/* File: design/dir_decoder.sv */
// instruction attribute and resource decoder with bit-test and borrow datapath
`timescale 1ns/1ps
`default_nettype none
module dir_decoder
	import dir_pkg::*;
#(
	parameter int ACC_W  = DIR_ACC_W,
	parameter int WORD_W = DIR_WORD_W
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_b,
	input  wire dir_req_t          i_req,
	input  wire logic              i_carry,
	output var  logic              o_valid,
	output var  dir_desc_t         o_desc,
	output var  logic              o_test_flag_one,
	output var  logic              o_test_flag_two,
	output var  logic              o_wr_en,
	output var  logic [WORD_W-1:0] o_wr_word,
	output var  logic              o_carry_upd,
	output var  logic              o_carry,
	output var  logic [ACC_W-1:0]  o_destination_accumulator
);
	if (ACC_W != 40 || WORD_W != 16) begin
		$error("decoder datapath is fixed at 40-bit accumulator and 16-bit word");
	end

	localparam logic [DIR_U_W-1:0] UN_NONE = '0;

	function automatic logic [DIR_U_W-1:0] u(input int pos);
		logic [DIR_U_W-1:0] m;
		m      = '0;
		m[pos] = 1'b1;
		return m;
	endfunction

	function automatic dir_desc_t mk(
		input logic               par,
		input logic [2:0]         sz,
		input logic [2:0]         cyc,
		input dir_stage_t         st,
		input logic [DIR_U_W-1:0] un,
		input logic [1:0]         da,
		input logic [1:0]         sa,
		input logic [1:0]         dr,
		input logic [1:0]         dw
	);
		dir_desc_t d;
		d.legal             = 1'b1;
		d.par_en            = par;
		d.size              = sz;
		d.cycles            = cyc;
		d.stage             = st;
		d.units             = un;
		d.data_address_gen  = da;
		d.stack_address_gen = sa;
		d.data_read_bus     = dr;
		d.data_write_bus    = dw;
		return d;
	endfunction

	dir_desc_t          desc_nxt;
	logic [DIR_U_W-1:0] sh1_units;
	logic               bit_orig;
	logic [WORD_W-1:0]  bit_word;
	logic               is_clr;
	logic               is_cpl;
	logic               is_set;
	logic               is_tst;
	logic [ACC_W-1:0]   sub_res;
	logic               sub_carry;
	logic               use_borrow;

	// shifts by one on an address-unit register also need the address ALU
	always_comb begin
		if (i_req.dst_au) begin
			sh1_units = u(DIR_U_ADDRESS_UNIT_ALU) | u(DIR_U_DATA_UNIT_SHIFTER);
		end else begin
			sh1_units = u(DIR_U_DATA_UNIT_SHIFTER);
		end
	end

	// pure table decode; unknown ids give an all-zero, non-legal descriptor
	always_comb begin
		desc_nxt = DIR_DESC_RST;
		case (i_req.instr)
			DIR_I_LSL1: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, sh1_units,
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_LSR1: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, sh1_units,
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_LSL_IMM: begin
				desc_nxt = mk(1'b1, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_ASR1: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, sh1_units,
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_ASL1: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, sh1_units,
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_ASH_TX: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_ASH_IMM: begin
				desc_nxt = mk(1'b1, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SOFT_INT: begin
				desc_nxt = mk(1'b0, 3'h2, 3'h3, DIR_STG_D, u(DIR_U_PU_UNIT),
					2'h1, 2'h1, 2'h0, 2'h2);
			end
			DIR_I_SQR_REG, DIR_I_SQRA_REG, DIR_I_SQRS_REG: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_MAC_ONE),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SQR_MEM, DIR_I_SQRA_MEM, DIR_I_SQRS_MEM: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_MAC_ONE),
					2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_SQDST: begin
				desc_nxt = mk(1'b0, 3'h4, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU) | u(DIR_U_DATA_UNIT_MAC_ONE),
					2'h2, 2'h0, 2'h2, 2'h0);
			end
			DIR_I_ST_HI: begin
				desc_nxt = mk(1'b0, 3'h2, 3'h1, DIR_STG_X, UN_NONE,
					2'h1, 2'h0, 2'h0, 2'h1);
			end
			DIR_I_ST_HI_RND, DIR_I_ST_LO_SHIMM, DIR_I_ST_HI_USAT: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h1, 2'h0, 2'h0, 2'h1);
			end
			DIR_I_ST_HI_RNDIMM: begin
				desc_nxt = mk(1'b0, 3'h4, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h1, 2'h0, 2'h0, 2'h1);
			end
			DIR_I_ST_HI_USATIMM: begin
				desc_nxt = mk(1'b0, 3'h4, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h1, 2'h0, 2'h0, 2'h1);
			end
			DIR_I_ST_DBL: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, UN_NONE,
					2'h1, 2'h0, 2'h0, 2'h2);
			end
			DIR_I_ST_DBL_USAT: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h1, 2'h0, 2'h0, 2'h2);
			end
			DIR_I_ST_HALF_SHR1: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h1, 2'h0, 2'h0, 2'h2);
			end
			DIR_I_ST_DUAL_LOHI: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, UN_NONE,
					2'h2, 2'h0, 2'h0, 2'h2);
			end
			DIR_I_SUBC: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU),
					2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_SUB_REG: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X,
					i_req.dst_au ? u(DIR_U_ADDRESS_UNIT_ALU) : u(DIR_U_DATA_UNIT_ALU), 2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SUB_K16: begin
				desc_nxt = mk(1'b0, 3'h4, 3'h1, DIR_STG_X,
					i_req.dst_au ? u(DIR_U_ADDRESS_UNIT_ALU) : u(DIR_U_DATA_UNIT_ALU), 2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SUB_MEM: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X,
					i_req.dst_au ? u(DIR_U_ADDRESS_UNIT_ALU) : u(DIR_U_DATA_UNIT_ALU), 2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_SUB_ACC_TX: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SUB_ACC_IMM: begin
				desc_nxt = mk(1'b1, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_SHIFTER),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SUB_MEM16: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU),
					2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_SUB_REV16: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU),
					2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_SUB_BORROW: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU),
					2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_SUB_UNS: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU),
					2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_SUB_DBL: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU),
					2'h1, 2'h0, 2'h2, 2'h0);
			end
			DIR_I_SUB_DUAL16: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU),
					2'h2, 2'h0, 2'h2, 2'h0);
			end
			DIR_I_SUB_PAR_ST: begin
				desc_nxt = mk(1'b0, 3'h4, 3'h1, DIR_STG_X, u(DIR_U_DATA_UNIT_ALU) | u(DIR_U_DATA_UNIT_SHIFTER),
					2'h2, 2'h0, 2'h2, 2'h2);
			end
			DIR_I_SWAP_ACC: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_X, u(DIR_U_DU_SWAP),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SWAP_AR, DIR_I_SWAP_AR_T, DIR_I_SWAP_T: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_AD, u(DIR_U_ADDRESS_UNIT_SWAPPER),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_SWAP_BLOCK: begin
				desc_nxt = mk(1'b1, 3'h2, 3'h1, DIR_STG_AD, u(DIR_U_ADDRESS_UNIT_SWAPPER),
					2'h0, 2'h0, 2'h0, 2'h0);
			end
			DIR_I_BIT_TST: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_ADDRESS_UNIT_ALU),
					2'h1, 2'h0, 2'h1, 2'h0);
			end
			DIR_I_BIT_TST_CLR, DIR_I_BIT_TST_CPL, DIR_I_BIT_TST_SET: begin
				desc_nxt = mk(1'b0, 3'h3, 3'h1, DIR_STG_X, u(DIR_U_ADDRESS_UNIT_ALU),
					2'h1, 2'h0, 2'h1, 2'h1);
			end
			default: begin
				desc_nxt = DIR_DESC_RST;
			end
		endcase
	end

	always_comb begin
		is_clr     = i_req.instr == DIR_I_BIT_TST_CLR;
		is_cpl     = i_req.instr == DIR_I_BIT_TST_CPL;
		is_set     = i_req.instr == DIR_I_BIT_TST_SET;
		is_tst     = is_clr | is_cpl | is_set | (i_req.instr == DIR_I_BIT_TST);
		use_borrow = i_req.instr == DIR_I_SUB_BORROW;
	end

	dir_bit_modify #(
		.W (WORD_W)
	) u_bit (
		.i_word     (i_req.mem_word),
		.i_idx      (i_req.bit_idx),
		.i_clr      (is_clr),
		.i_cpl      (is_cpl),
		.i_set      (is_set),
		.o_orig_bit (bit_orig),
		.o_word     (bit_word)
	);

	// plain unsigned subtract shares the path with the borrow disabled
	dir_sub_borrow #(
		.AW (ACC_W),
		.WW (WORD_W)
	) u_sub (
		.i_acc        (i_req.source_accumulator),
		.i_word       (i_req.mem_word),
		.i_carry      (i_carry),
		.i_use_borrow (use_borrow),
		.o_res        (sub_res),
		.o_carry      (sub_carry)
	);

	// descriptor stage, one per accepted request
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_valid <= 1'b0;
			o_desc  <= DIR_DESC_RST;
		end else begin
			o_valid <= i_req.valid;
			if (i_req.valid) begin
				o_desc <= desc_nxt;
			end
		end
	end

	// test flags are sticky state; only bit tests touch them
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_test_flag_one <= DIR_TFLAG_RST;
			o_test_flag_two <= DIR_TFLAG_RST;
		end else if (i_req.valid && is_tst) begin
			if (i_req.tc_sel) begin
				o_test_flag_two <= bit_orig;
			end else begin
				o_test_flag_one <= bit_orig;
			end
		end
	end

	// write-back word for bit modify; plain test writes nothing
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wr_en   <= 1'b0;
			o_wr_word <= '0;
		end else begin
			o_wr_en <= i_req.valid & (is_clr | is_cpl | is_set);
			if (i_req.valid && (is_clr || is_cpl || is_set)) begin
				o_wr_word <= bit_word;
			end
		end
	end

	// carry holds the inverted borrow of the unsigned subtract forms
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_carry_upd               <= 1'b0;
			o_carry                   <= DIR_CARRY_RST;
			o_destination_accumulator <= '0;
		end else begin
			o_carry_upd <= i_req.valid & (use_borrow | (i_req.instr == DIR_I_SUB_UNS));
			if (i_req.valid && (use_borrow || i_req.instr == DIR_I_SUB_UNS)) begin
				o_carry                   <= sub_carry;
				o_destination_accumulator <= sub_res;
			end
		end
	end
endmodule
`default_nettype wire

/* File: test/dir_decoder_sva.sv */
// concurrent checks on the resource decoder ports
`timescale 1ns/1ps
`default_nettype none
module dir_decoder_sva
	import dir_pkg::*;
#(
	parameter int ACC_W  = DIR_ACC_W,
	parameter int WORD_W = DIR_WORD_W
) (
	input wire logic              i_clk_sys,
	input wire logic              i_rst_b,
	input wire dir_req_t          i_req,
	input wire logic              i_carry,
	input wire logic              o_valid,
	input wire dir_desc_t         o_desc,
	input wire logic              o_test_flag_one,
	input wire logic              o_test_flag_two,
	input wire logic              o_wr_en,
	input wire logic [WORD_W-1:0] o_wr_word,
	input wire logic              o_carry_upd,
	input wire logic              o_carry,
	input wire logic [ACC_W-1:0]  o_destination_accumulator
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	dir_req_t          q_r;
	logic              c_r;
	logic [ACC_W:0]    d_w;
	logic [WORD_W-1:0] m_w;
	logic [WORD_W-1:0] e_w;
	// last request kept so each output is tied to its cause, not to itself
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q_r <= '0;
			c_r <= 1'b0;
		end else begin
			q_r <= i_req;
			c_r <= i_carry;
		end
	end
	assign d_w = {1'b0, q_r.source_accumulator} - {{(ACC_W-15){1'b0}}, q_r.mem_word}
		- {{ACC_W{1'b0}}, ~c_r};
	assign m_w = {{(WORD_W-1){1'b0}}, 1'b1} << q_r.bit_idx;
	always_comb begin
		case (q_r.instr)
			DIR_I_BIT_TST_CLR: e_w = q_r.mem_word & ~m_w;
			DIR_I_BIT_TST_CPL: e_w = q_r.mem_word ^ m_w;
			default:           e_w = q_r.mem_word | m_w;
		endcase
	end
	sequence s_took(dir_instr_t k);
		q_r.valid && q_r.instr == k;
	endsequence
	sequence s_mod;
		q_r.valid && q_r.instr inside {DIR_I_BIT_TST_CLR, DIR_I_BIT_TST_CPL, DIR_I_BIT_TST_SET};
	endsequence
	property p_answer;
		i_req.valid |=> o_valid;
	endproperty
	property p_quiet;
		!i_req.valid |=> !o_valid;
	endproperty
	property p_sqdst;
		s_took(DIR_I_SQDST) |-> o_desc == {2'b10, 3'd4, 3'd1, DIR_STG_X, 7'h03, 8'h88};
	endproperty
	property p_sqr_reg;
		s_took(DIR_I_SQR_REG) |-> o_desc == {2'b11, 3'd2, 3'd1, DIR_STG_X, 7'h02, 8'h00};
	endproperty
	property p_shift1;
		q_r.valid && q_r.instr inside {DIR_I_LSL1, DIR_I_LSR1, DIR_I_ASR1, DIR_I_ASL1}
		|-> o_desc.units == (q_r.dst_au ? 7'h14 : 7'h04) && o_desc.par_en && o_desc.size == 3'd2;
	endproperty
	property p_swap_blk;
		s_took(DIR_I_SWAP_BLOCK) |-> o_desc.stage == DIR_STG_AD && o_desc.units == 7'h20;
	endproperty
	property p_borrow;
		s_took(DIR_I_SUB_BORROW) |-> o_carry_upd && o_carry == !d_w[ACC_W]
		&& o_destination_accumulator == d_w[ACC_W-1:0];
	endproperty
	property p_flag;
		s_mod |-> o_wr_en && (q_r.tc_sel ? o_test_flag_two : o_test_flag_one)
		== q_r.mem_word[q_r.bit_idx];
	endproperty
	property p_wr_word;
		s_mod |-> o_wr_word == e_w;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer one cycle after request");
	a_quiet: assert property (p_quiet) else $error("answer without request");
	a_sqdst: assert property (p_sqdst) else $error("square distance descriptor wrong");
	a_sqr_reg: assert property (p_sqr_reg) else $error("register square descriptor wrong");
	a_shift1: assert property (p_shift1) else $error("shift by one units wrong");
	a_swap_blk: assert property (p_swap_blk) else $error("block swap stage wrong");
	a_borrow: assert property (p_borrow) else $error("borrow subtract wrong");
	a_flag: assert property (p_flag) else $error("test flag wrong");
	a_wr_word: assert property (p_wr_word) else $error("write-back word wrong");
endmodule
bind dir_decoder dir_decoder_sva #(.ACC_W(ACC_W), .WORD_W(WORD_W)) i_sva (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_req(i_req), .i_carry(i_carry),
	.o_valid(o_valid), .o_desc(o_desc), .o_test_flag_one(o_test_flag_one),
	.o_test_flag_two(o_test_flag_two), .o_wr_en(o_wr_en), .o_wr_word(o_wr_word),
	.o_carry_upd(o_carry_upd), .o_carry(o_carry),
	.o_destination_accumulator(o_destination_accumulator));
`default_nettype wire

/* File: test/dir_mem_model.sv */
// data memory behind the read and write buses
`timescale 1ns/1ps
`default_nettype none
module dir_mem_model
	import dir_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	input  wire logic        i_valid,
	input  wire logic [3:0]  i_addr,
	input  wire logic        i_wr_en,
	input  wire logic [15:0] i_wr_word,
	output logic [15:0]      o_rd_word
);
	logic [15:0] mem_r [16];
	logic [3:0]  wa_r;
	// idle bus shows the inverse so a stale sample cannot pass
	assign o_rd_word = i_valid ? mem_r[i_addr] : ~mem_r[i_addr];
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wa_r <= 4'h0;
			for (int k = 0; k < 16; k++) begin
				mem_r[k] <= 16'ha5c3 ^ {4{k[3:0]}};
			end
		end else begin
			if (i_valid) begin
				wa_r <= i_addr;
			end
			if (i_wr_en) begin
				mem_r[wa_r] <= i_wr_word;
			end
		end
	end
endmodule
`default_nettype wire

/* File: test/dir_decoder_tb_top.sv */
// self-checking bench for the resource decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dir_decoder_tb_top
	import dir_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	dir_req_t req_r = '0;
	dir_req_t dut_req;
	logic [3:0] addr_r = 4'h0;
	logic carry_r = 1'b0;
	logic [15:0] rd_word;
	logic [15:0] shadow [16];
	logic o_valid, f1, f2, wr_en, c_upd, o_carry;
	dir_desc_t o_desc;
	logic [15:0] wr_word;
	logic [39:0] acc_out;
	int error_cnt = 0;
	int total_checks = 0;
	dir_instr_t lst [18] = '{DIR_I_SQDST, DIR_I_SQR_REG, DIR_I_SQRA_MEM, DIR_I_ST_HALF_SHR1,
		DIR_I_ST_DUAL_LOHI, DIR_I_ST_HI_USATIMM, DIR_I_SUB_BORROW, DIR_I_SUB_REV16,
		DIR_I_SUB_PAR_ST, DIR_I_LSL1, DIR_I_LSR1, DIR_I_ASR1, DIR_I_ASL1, DIR_I_SWAP_BLOCK,
		DIR_I_BIT_TST_CLR, DIR_I_BIT_TST_CPL, DIR_I_BIT_TST_SET, DIR_I_SUB_ACC_IMM};
	always #2.5 clk = ~clk;
	always_comb begin
		dut_req = req_r;
		dut_req.mem_word = rd_word;
	end
	dir_decoder i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_req(dut_req), .i_carry(carry_r),
		.o_valid(o_valid), .o_desc(o_desc), .o_test_flag_one(f1), .o_test_flag_two(f2),
		.o_wr_en(wr_en), .o_wr_word(wr_word), .o_carry_upd(c_upd), .o_carry(o_carry),
		.o_destination_accumulator(acc_out));
	dir_mem_model i_mem (.i_clk_sys(clk), .i_rst_b(rst_b), .i_valid(req_r.valid),
		.i_addr(addr_r), .i_wr_en(wr_en), .i_wr_word(wr_word), .o_rd_word(rd_word));
	// table of what each covered instruction must claim; others are illegal
	function automatic dir_desc_t exp_desc(dir_instr_t k, logic au);
		case (k)
			DIR_I_SQDST:         return {2'b10, 3'd4, 3'd1, DIR_STG_X, 7'h03, 8'h88};
			DIR_I_SQR_REG:       return {2'b11, 3'd2, 3'd1, DIR_STG_X, 7'h02, 8'h00};
			DIR_I_SQRA_MEM:      return {2'b10, 3'd3, 3'd1, DIR_STG_X, 7'h02, 8'h44};
			DIR_I_ST_HALF_SHR1:  return {2'b10, 3'd3, 3'd1, DIR_STG_X, 7'h04, 8'h42};
			DIR_I_ST_DUAL_LOHI:  return {2'b10, 3'd3, 3'd1, DIR_STG_X, 7'h00, 8'h82};
			DIR_I_ST_HI_USATIMM: return {2'b10, 3'd4, 3'd1, DIR_STG_X, 7'h04, 8'h41};
			DIR_I_SUB_BORROW, DIR_I_SUB_UNS,
			DIR_I_SUB_REV16:     return {2'b10, 3'd3, 3'd1, DIR_STG_X, 7'h01, 8'h44};
			DIR_I_BIT_TST:       return {2'b10, 3'd3, 3'd1, DIR_STG_X, 7'h10, 8'h44};
			DIR_I_SUB_PAR_ST:    return {2'b10, 3'd4, 3'd1, DIR_STG_X, 7'h05, 8'h8a};
			DIR_I_LSL1, DIR_I_LSR1, DIR_I_ASR1, DIR_I_ASL1:
				return {2'b11, 3'd2, 3'd1, DIR_STG_X, au ? 7'h14 : 7'h04, 8'h00};
			DIR_I_SWAP_BLOCK:    return {2'b11, 3'd2, 3'd1, DIR_STG_AD, 7'h20, 8'h00};
			DIR_I_BIT_TST_CLR, DIR_I_BIT_TST_CPL,
			DIR_I_BIT_TST_SET:   return {2'b10, 3'd3, 3'd1, DIR_STG_X, 7'h10, 8'h45};
			DIR_I_SUB_ACC_IMM:   return {2'b11, 3'd3, 3'd1, DIR_STG_X, 7'h04, 8'h00};
			default:             return '0;
		endcase
	endfunction
	task automatic init_shadow;
		for (int k = 0; k < 16; k++) begin
			shadow[k] = 16'ha5c3 ^ {4{k[3:0]}};
		end
	endtask
	task automatic run(dir_instr_t k, logic au, logic tc, logic [3:0] ix, logic [3:0] ad,
		logic [39:0] acc, logic cy);
		logic [15:0] w;
		logic [15:0] m;
		logic [15:0] ew;
		logic [40:0] d;
		logic is_mod;
		logic is_sub;
		@(posedge clk);
		w = shadow[ad];
		req_r <= '{1'b1, k, au, tc, ix, 16'h0, acc};
		addr_r <= ad;
		carry_r <= cy;
		@(posedge clk);
		#1;
		`CHK(o_valid, 1'b1)
		`CHK(o_desc, exp_desc(k, au))
		m = 16'h1 << ix;
		is_mod = k inside {DIR_I_BIT_TST_CLR, DIR_I_BIT_TST_CPL, DIR_I_BIT_TST_SET};
		is_sub = k inside {DIR_I_SUB_BORROW, DIR_I_SUB_UNS};
		`CHK(wr_en, is_mod)
		`CHK(c_upd, is_sub)
		if (is_mod || k == DIR_I_BIT_TST) begin
			`CHK(tc ? f2 : f1, w[ix])
		end
		if (is_mod) begin
			ew = k == DIR_I_BIT_TST_CLR ? w & ~m : k == DIR_I_BIT_TST_CPL ? w ^ m : w | m;
			`CHK(wr_word, ew)
			shadow[ad] = ew;
		end
		if (is_sub) begin
			// only the borrow form pulls in the inverted stored carry
			d = {1'b0, acc} - {25'h0, w} - {40'h0, ~cy & (k == DIR_I_SUB_BORROW)};
			`CHK(acc_out, d[39:0])
			`CHK(o_carry, ~d[40])
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#40000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		init_shadow();
		void'($urandom(32'hd32cc443));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 36; i++) begin
			run(lst[i / 2], i[0], i[0], i[4:1], i[3:0], 40'h5, 1'b0);
		end
		$display("test table done");
		// wrap below zero, full accumulator, top bit of a word, illegal id
		run(DIR_I_SUB_BORROW, 1'b0, 1'b0, 4'h0, 4'h1, 40'h0, 1'b0);
		run(DIR_I_SUB_BORROW, 1'b0, 1'b0, 4'h0, 4'h2, 40'hff_ffff_ffff, 1'b1);
		run(DIR_I_BIT_TST_CPL, 1'b0, 1'b1, 4'hf, 4'h3, 40'h0, 1'b0);
		run(DIR_I_BIT_TST_CPL, 1'b0, 1'b0, 4'hf, 4'h3, 40'h0, 1'b0);
		run(DIR_I_SUB_UNS, 1'b0, 1'b0, 4'h0, 4'h5, 40'h3, 1'b0);
		run(DIR_I_BIT_TST, 1'b0, 1'b1, 4'h7, 4'h6, 40'h0, 1'b1);
		run(dir_instr_t'(6'h3f), 1'b1, 1'b0, 4'h0, 4'h0, 40'h0, 1'b0);
		@(posedge clk);
		req_r.valid <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(o_valid, 1'b0)
		$display("test corners done");
		for (int i = 0; i < 80; i++) begin
			run(lst[$urandom_range(17, 0)], 1'($urandom), 1'($urandom), 4'($urandom),
				4'($urandom), {8'($urandom), 32'($urandom)}, 1'($urandom));
		end
		$display("test random done");
		@(posedge clk);
		rst_b <= 1'b0;
		req_r.valid <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(o_valid, 1'b0)
		`CHK(o_desc, DIR_DESC_RST)
		init_shadow();
		@(posedge clk);
		rst_b <= 1'b1;
		run(DIR_I_BIT_TST_SET, 1'b0, 1'b1, 4'h3, 4'h4, 40'h0, 1'b0);
		$display("test reset done");
		wrap_up();
	end
endmodule
`default_nettype wire
